// ==== scsr_top.sv ====
// APB register bank returning module error code and two channel status words.
// Assumes a single 25 MHz pclk and asynchronous active-low presetn.
//
// Added by the designer: the APB slave port.
`include "scsr_map.svh"
`default_nettype none
module scsr_top
   import scsr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic update_tick,
   input wire logic self_test_done,
   input wire logic command_accepted,
   input wire logic exc_measure_fail,
   input wire logic [1:0] sensor_fault,
   input wire logic [1:0] sensor_reading,
   input wire logic [1:0] calib_valid,
   input wire logic [31:0] adc_null,
   output logic [1:0] zero_motion,
   output logic [3:0] error_code,
   output logic excitation_output_pin
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [3:0] err;
      logic ready_flag;
      logic done_seen;
      logic meas_mode;
      logic align_mode;
      logic [1:0] null_set;
      logic [3:0] null_dir;
      logic [1:0] cfg_valid;
      logic [3:0] sens_type;
      logic [31:0] value_a;
      logic [31:0] value_b;
      logic [15:0] word1;
      logic [15:0] word2;
      logic [1:0] zero_motion;
      logic exc_on;
   } scsr_state_type;

   scsr_state_type s_r;
   scsr_state_type s_nxt;
   scsr_chan_type chan [2];
   logic [15:0] word [2];
   logic [1:0] zm;
   logic [3:0] chk_code;
   logic [2:0] chk_kind;
   logic chk_go;
   logic [3:0] idx;
   logic wr_acc;
   logic rd_acc;
   logic mapped;

   // ----------------------------------------
   // Channel status packing
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         always_comb begin
            chan[g].meas_mode = s_r.meas_mode;
            chan[g].align_mode = s_r.align_mode;
            chan[g].null_setting = s_r.null_set[g];
            chan[g].null_dir = s_r.null_dir[2*g +: 2];
            chan[g].calibrated = calib_valid[g];
            chan[g].configured = s_r.cfg_valid[g];
            chan[g].fault = sensor_fault[g];
            chan[g].measuring = sensor_reading[g];
            chan[g].sensor_type = s_r.sens_type[2*g +: 2];
         end
         scsr_status_word u_word (
            .chan(chan[g]),
            .word(word[g]),
            .zero_motion(zm[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Error checks
   // ----------------------------------------
   scsr_error_check u_check (
      .kind(chk_kind),
      .value_a(s_r.value_a),
      .value_b(s_r.value_b),
      .null_ref(adc_null),
      .exc_fail(exc_measure_fail & s_r.exc_on),
      .code(chk_code)
   );

   // ----------------------------------------
   // APB decode and next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      idx = paddr[5:2];
      wr_acc = psel & penable & pwrite & s_r.pready;
      rd_acc = psel & ~penable & ~pwrite;
      chk_go = 1'b0;
      chk_kind = pwdata[2:0];
      mapped = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00);
      if (idx == `SCSR_IDX_ERROR) begin
         mapped = mapped;
      end else if (idx == `SCSR_IDX_CH1_STATUS || idx == `SCSR_IDX_CH2_STATUS) begin
         mapped = mapped;
      end else if (idx >= `SCSR_IDX_CTRL && idx <= `SCSR_IDX_CLEAR) begin
         mapped = mapped;
      end else begin
         mapped = 1'b0;
      end

      // No wait state: setup cycle prepares, first access cycle completes
      s_nxt.pready = psel & ~penable;
      s_nxt.pslverr = psel & ~penable & ~mapped;
      if (rd_acc) begin
         if (!mapped) begin
            s_nxt.prdata = 32'h0000_0000;
         end else if (idx == `SCSR_IDX_ERROR) begin
            s_nxt.prdata = {28'h000_0000, s_r.err};
         end else if (idx == `SCSR_IDX_CH1_STATUS) begin
            s_nxt.prdata = {16'h0000, s_r.word1};
         end else if (idx == `SCSR_IDX_CH2_STATUS) begin
            s_nxt.prdata = {16'h0000, s_r.word2};
         end else if (idx == `SCSR_IDX_CTRL) begin
            s_nxt.prdata = {24'h00_0000, s_r.null_dir, s_r.null_set, s_r.align_mode, s_r.meas_mode};
         end else if (idx == `SCSR_IDX_CH1_CFG || idx == `SCSR_IDX_CH2_CFG) begin
            s_nxt.prdata = {28'h000_0000, s_r.cfg_valid, s_r.exc_on, 1'b0};
         end else if (idx == `SCSR_IDX_VALUE_A) begin
            s_nxt.prdata = s_r.value_a;
         end else if (idx == `SCSR_IDX_VALUE_B) begin
            s_nxt.prdata = s_r.value_b;
         end else begin
            s_nxt.prdata = 32'h0000_0000;
         end
      end

      if (wr_acc && mapped) begin
         if (idx == `SCSR_IDX_CTRL) begin
            s_nxt.meas_mode = pwdata[0];
            s_nxt.align_mode = pwdata[1];
            s_nxt.null_set = pwdata[3:2];
            s_nxt.null_dir = pwdata[7:4];
         end else if (idx == `SCSR_IDX_CH1_CFG) begin
            s_nxt.sens_type[1:0] = pwdata[1:0];
            s_nxt.cfg_valid[0] = pwdata[2];
            s_nxt.exc_on = pwdata[3];
         end else if (idx == `SCSR_IDX_CH2_CFG) begin
            s_nxt.sens_type[3:2] = pwdata[1:0];
            s_nxt.cfg_valid[1] = pwdata[2];
            s_nxt.exc_on = pwdata[3];
         end else if (idx == `SCSR_IDX_VALUE_A) begin
            s_nxt.value_a = pwdata;
         end else if (idx == `SCSR_IDX_VALUE_B) begin
            s_nxt.value_b = pwdata;
         end else if (idx == `SCSR_IDX_CHECK) begin
            chk_go = 1'b1;
         end else if (idx == `SCSR_IDX_CLEAR) begin
            s_nxt.err = `SCSR_ERR_NONE;
         end
      end

      // Check result latched; a clean check keeps the earlier code
      if (chk_go && chk_code != `SCSR_ERR_NONE) begin
         s_nxt.err = chk_code;
      end
      // Excitation loss is a level and is raised even over a clear
      if (exc_measure_fail && s_r.exc_on) begin
         s_nxt.err = `SCSR_ERR_EXC;
      end

      // Ready flag: raised once after self test, dropped on first command
      if (self_test_done && !s_r.done_seen) begin
         s_nxt.done_seen = 1'b1;
         s_nxt.ready_flag = 1'b1;
      end
      if (command_accepted && s_r.done_seen) begin
         s_nxt.ready_flag = 1'b0;
      end

      if (update_tick) begin
         s_nxt.word1 = word[0] | {3'b000, s_r.ready_flag, 12'h000};
         s_nxt.word2 = word[1] | {3'b000, s_r.ready_flag, 12'h000};
         s_nxt.zero_motion = zm;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign error_code = s_r.err;
   assign zero_motion = s_r.zero_motion;
   assign excitation_output_pin = s_r.exc_on;
endmodule
`default_nettype wire

// ==== scsr_map.svh ====
// Register offsets, field positions, limits and codes for the channel status block.
// Assumes inclusion by every design module of the block (not the package), after any header comment.
// Function
// - Sensitivity outside 1..50000 gives code 5
// - Displacement outside 5..10000 gives code 6
// - Null request beyond 255 counts: code 7
// - Min/max beyond 65535 from null: code 8
// - Min/max under 100 counts from null: 8
// - Min and max same side: code 8
// - Two-point min equals max: code 8
// - Codes 9-11 and 13-15 never reported
// - Excitation not measurable gives code 12
// - Status words 1 and 5, fixed layout
// - Bits 15,11,10,7,6,3,2 always zero
// - Bit 14 shows valid calibration
// - Bit 13 shows valid configuration
// - Bit 12 ready after reset, cleared on command
// - Bits 9:8 null direction while aligning null
// - Bit 5 flags sensor read fault
// - Bit 4 measuring; else zero position
// - Bits 1:0 carry programmed sensor type
`ifndef SCSR_MAP_SVH
`define SCSR_MAP_SVH

// ----------------------------------------
// Register word indices, byte address is index times four
// ----------------------------------------
`define SCSR_IDX_CH1_STATUS 4'h1
`define SCSR_IDX_CH2_STATUS 4'h5
`define SCSR_IDX_ERROR 4'h0
`define SCSR_IDX_CTRL 4'h8
`define SCSR_IDX_CH1_CFG 4'h9
`define SCSR_IDX_CH2_CFG 4'hA
`define SCSR_IDX_CHECK 4'hB
`define SCSR_IDX_VALUE_A 4'hC
`define SCSR_IDX_VALUE_B 4'hD
`define SCSR_IDX_CLEAR 4'hE

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define SCSR_BIT_CAL 14
`define SCSR_BIT_CFG 13
`define SCSR_BIT_READY 12
`define SCSR_BIT_NULL_HI 9
`define SCSR_BIT_NULL_LO 8
`define SCSR_BIT_FAULT 5
`define SCSR_BIT_MEAS 4

// ----------------------------------------
// Error codes and limits
// ----------------------------------------
`define SCSR_ERR_NONE 4'h0
`define SCSR_ERR_SENS 4'h5
`define SCSR_ERR_DISP 4'h6
`define SCSR_ERR_NULL 4'h7
`define SCSR_ERR_MINMAX 4'h8
`define SCSR_ERR_EXC 4'hC
`define SCSR_SENS_MIN 32'h0000_0001
`define SCSR_SENS_MAX 32'h0000_C350
`define SCSR_DISP_MIN 32'h0000_0005
`define SCSR_DISP_MAX 32'h0000_2710
`define SCSR_NULL_WIN 32'h0000_00FF
`define SCSR_SPAN_MAX 32'h0000_FFFF
`define SCSR_SEP_MIN 32'h0000_0064

// ----------------------------------------
// Check kinds written to the check register
// ----------------------------------------
`define SCSR_CHK_SENS 3'h1
`define SCSR_CHK_DISP 3'h2
`define SCSR_CHK_NULL 3'h3
`define SCSR_CHK_MINMAX 3'h4
`define SCSR_CHK_TWOPT 3'h5

`endif

// ==== scsr_pkg.sv ====
// Types shared by the channel status block.
// Assumes the map header is compiled alongside.
`default_nettype none
package scsr_pkg;
   typedef struct packed {
      logic meas_mode;
      logic align_mode;
      logic null_setting;
      logic [1:0] null_dir;
      logic calibrated;
      logic configured;
      logic fault;
      logic measuring;
      logic [1:0] sensor_type;
   } scsr_chan_type;

   typedef struct packed {
      logic [3:0] paddr_idx;
      logic write;
      logic [31:0] wdata;
   } scsr_req_type;
endpackage
`default_nettype wire

// ==== scsr_status_word.sv ====
// Packs one channel's flags into a 16-bit status word.
// Assumes mode and setup flags registered by the caller; calibration, fault and measuring flags arrive unregistered.
`include "scsr_map.svh"
`default_nettype none
module scsr_status_word
   import scsr_pkg::*;
(
   input wire scsr_chan_type chan,
   output logic [15:0] word,
   output logic zero_motion
);
   always_comb begin
      word = 16'h0000;
      word[`SCSR_BIT_CAL] = chan.calibrated;
      word[`SCSR_BIT_CFG] = chan.configured;
      // Null field only live while setting null in alignment
      if (chan.align_mode && chan.null_setting) begin
         word[`SCSR_BIT_NULL_HI:`SCSR_BIT_NULL_LO] = chan.null_dir;
      end
      // Fault is meaningless outside alignment and measurement
      word[`SCSR_BIT_FAULT] = chan.fault & (chan.align_mode | chan.meas_mode);
      word[`SCSR_BIT_MEAS] = chan.measuring & chan.meas_mode;
      word[1:0] = chan.sensor_type;
      zero_motion = chan.meas_mode & ~chan.measuring;
   end
endmodule
`default_nettype wire

// ==== scsr_error_check.sv ====
// Range and alignment checks that yield a module error code.
// Assumes operands are held stable for the cycle that chk_go is high.
`include "scsr_map.svh"
`default_nettype none
module scsr_error_check (
   input wire logic [2:0] kind,
   input wire logic [31:0] value_a,
   input wire logic [31:0] value_b,
   input wire logic [31:0] null_ref,
   input wire logic exc_fail,
   output logic [3:0] code
);
   logic signed [33:0] da;
   logic signed [33:0] db;
   logic [33:0] ma;
   logic [33:0] mb;
   always_comb begin
      da = $signed({2'b00, value_a}) - $signed({2'b00, null_ref});
      db = $signed({2'b00, value_b}) - $signed({2'b00, null_ref});
      ma = da[33] ? 34'(-da) : 34'(da);
      mb = db[33] ? 34'(-db) : 34'(db);
      code = `SCSR_ERR_NONE;
      case (kind)
         `SCSR_CHK_SENS: begin
            if (value_a < `SCSR_SENS_MIN || value_a > `SCSR_SENS_MAX) begin
               code = `SCSR_ERR_SENS;
            end
         end
         `SCSR_CHK_DISP: begin
            if (value_a < `SCSR_DISP_MIN || value_a > `SCSR_DISP_MAX) begin
               code = `SCSR_ERR_DISP;
            end
         end
         `SCSR_CHK_NULL: begin
            if (ma > {2'b00, `SCSR_NULL_WIN}) begin
               code = `SCSR_ERR_NULL;
            end
         end
         `SCSR_CHK_MINMAX: begin
            if (ma > {2'b00, `SCSR_SPAN_MAX} || mb > {2'b00, `SCSR_SPAN_MAX}) begin
               code = `SCSR_ERR_MINMAX;
            end else if (ma < {2'b00, `SCSR_SEP_MIN} || mb < {2'b00, `SCSR_SEP_MIN}) begin
               code = `SCSR_ERR_MINMAX;
            end else if (da[33] == db[33]) begin
               code = `SCSR_ERR_MINMAX;
            end
         end
         `SCSR_CHK_TWOPT: begin
            if (value_a == value_b) begin
               code = `SCSR_ERR_MINMAX;
            end
         end
         default: code = `SCSR_ERR_NONE;
      endcase
      // Excitation loss outranks any parameter error
      if (exc_fail) begin
         code = `SCSR_ERR_EXC;
      end
   end
endmodule
`default_nettype wire

// ==== scsr_checker.sv ====
// Concurrent checks on the bus and error-code ports of the status block.
// Assumes binding into scsr_top; sees its ports only.
`default_nettype none
module scsr_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic exc_measure_fail,
   input wire logic [3:0] error_code,
   input wire logic excitation_output_pin
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_st;
   logic wr_acc;
   assign rd_st = psel && penable && pready && !pwrite && (paddr == 8'h04 || paddr == 8'h14);
   assign wr_acc = psel && penable && pwrite;
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no answer after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_upper; rd_st |-> prdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("status upper half set");
   property p_rsvd; rd_st |-> {prdata[15], prdata[11:10], prdata[7:6], prdata[3:2]} == 7'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
   property p_legal; !(error_code inside {[4'h9:4'hB], [4'hD:4'hF]}); endproperty
   a_legal: assert property (p_legal) else $error("reserved code reported");
   property p_exc; exc_measure_fail && excitation_output_pin |-> ##[1:2] error_code == 4'hC; endproperty
   a_exc: assert property (p_exc) else $error("excitation loss not flagged");
   property p_cause; $changed(error_code) && error_code != 4'hC |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
   a_cause: assert property (p_cause) else $error("code moved without a write");
   c_rd: cover property (rd_st);
   c_slv: cover property (pslverr);
   c_mm: cover property (error_code == 4'h8);
endmodule

bind scsr_top scsr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .exc_measure_fail(exc_measure_fail), .error_code(error_code), .excitation_output_pin(excitation_output_pin));
`default_nettype wire

// ==== scsr_host.sv ====
// Bus host model: reads and writes the block over APB.
// Assumes the bench calls xfer and judges the results.
`default_nettype none
module scsr_host (
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // Request held until pready seen; bounded wait only
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err, output logic to);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      to = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the channel status block.
// Assumes the host model drives APB; all else driven here.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, update_tick, self_test_done;
   logic command_accepted, exc_measure_fail, excitation_output_pin, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, adc_null, rd;
   logic [1:0] sensor_fault, sensor_reading, calib_valid, zero_motion;
   logic [3:0] error_code;
   int fails, checks;
   scsr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .update_tick(update_tick), .self_test_done(self_test_done), .command_accepted(command_accepted),
      .exc_measure_fail(exc_measure_fail), .sensor_fault(sensor_fault), .sensor_reading(sensor_reading),
      .calib_valid(calib_valid), .adc_null(adc_null), .zero_motion(zero_motion),
      .error_code(error_code), .excitation_output_pin(excitation_output_pin));
   scsr_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic to;
      host.xfer(w, a, d, rd, perr, to);
      if (to) begin
         fails++;
         report_and_stop;
      end
   endtask
   task tick;
      @(posedge pclk) update_tick <= 1'b1;
      @(posedge pclk) update_tick <= 1'b0;
      @(posedge pclk);
   endtask
   // Clear first: a clean check keeps the old code
   task ck(input logic [2:0] k, input logic [31:0] a, input logic [31:0] b, input logic [3:0] e);
      rw(1'b1, 8'h38, 32'h0);
      rw(1'b1, 8'h30, a);
      rw(1'b1, 8'h34, b);
      rw(1'b1, 8'h2C, {29'h0, k});
      repeat (2) @(posedge pclk);
      chk("code", {28'h0, e}, {28'h0, error_code});
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {presetn, update_tick, self_test_done, command_accepted, exc_measure_fail} = 5'h00;
      {sensor_fault, sensor_reading, calib_valid} = 6'h00;
      adc_null = 32'h0000_03E8;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      tick;
      rw(1'b0, 8'h04, 32'h0);
      chk("ready", 32'h0, rd);
      @(posedge pclk) self_test_done <= 1'b1;
      tick;
      rw(1'b0, 8'h14, 32'h0);
      chk("ready", 32'h1000, rd);
      @(posedge pclk) command_accepted <= 1'b1;
      @(posedge pclk) command_accepted <= 1'b0;
      @(posedge pclk) calib_valid <= 2'b01;
      for (int t = 0; t < 4; t++) begin
         rw(1'b1, 8'h24, 32'h4 | t);
         rw(1'b1, 8'h28, 32'h3 - t);
         tick;
         rw(1'b0, 8'h04, 32'h0);
         chk("word1", 32'h6000 | t, rd);
         rw(1'b0, 8'h14, 32'h0);
         chk("word2", 32'h3 - t, rd);
      end
      @(posedge pclk) {sensor_reading, sensor_fault} <= 4'h6;
      rw(1'b1, 8'h20, 32'h25);
      tick;
      rw(1'b0, 8'h04, 32'h0);
      chk("word1", 32'h6013, rd);
      rw(1'b0, 8'h14, 32'h0);
      chk("word2", 32'h0020, rd);
      chk("zero", 32'h2, {30'h0, zero_motion});
      for (int d = 1; d < 4; d++) begin
         rw(1'b1, 8'h20, 32'h0E | (d << 4) | (d << 6));
         tick;
         rw(1'b0, 8'h04, 32'h0);
         chk("word1", 32'h6003 | (d << 8), rd);
         rw(1'b0, 8'h14, 32'h0);
         chk("word2", 32'h0020 | (d << 8), rd);
      end
      ck(3'h1, 32'h0, 32'h0, 4'h5);
      ck(3'h1, 32'hC351, 32'h0, 4'h5);
      ck(3'h1, 32'hC350, 32'h0, 4'h0);
      ck(3'h2, 32'h4, 32'h0, 4'h6);
      ck(3'h2, 32'h2711, 32'h0, 4'h6);
      ck(3'h2, 32'h5, 32'h0, 4'h0);
      ck(3'h3, 32'h4E8, 32'h0, 4'h7);
      ck(3'h3, 32'h2E9, 32'h0, 4'h0);
      ck(3'h4, 32'h103E8, 32'h320, 4'h8);
      ck(3'h4, 32'h44B, 32'h320, 4'h8);
      ck(3'h4, 32'h4B0, 32'h514, 4'h8);
      ck(3'h4, 32'h320, 32'h4B0, 4'h0);
      ck(3'h5, 32'h1F4, 32'h1F4, 4'h8);
      ck(3'h5, 32'h1F4, 32'h384, 4'h0);
      rw(1'b1, 8'h24, 32'hF);
      @(posedge pclk) exc_measure_fail <= 1'b1;
      chk("exc pin", 32'h1, {31'h0, excitation_output_pin});
      repeat (3) @(posedge pclk);
      rw(1'b1, 8'h38, 32'h0);
      rw(1'b0, 8'h00, 32'h0);
      chk("code reg", 32'hC, rd);
      rw(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, perr});
      chk("unmapped data", 32'h0, rd);
      report_and_stop;
   end
endmodule
`default_nettype wire
